// ==== core/oprl_recorder.sv ====
/*
 * Operations log input event recorder: watches the programmable logical inputs,
 * queues one pending record per input edge and emits one record per cycle,
 * fires event and waveform capture strobes and follows the element enables.
 * Assumes the log sink accepts a record on every cycle it is offered and that
 * the capture stores act on a one-cycle start strobe.
 */
`timescale 1ns/1ps

// What this block does
// R1: Trip command input falling logs an external-trip-disabled record.
// R2: Event trigger one rising logs initiated and captures; falling logs reset.
// R3: Event trigger two behaves the same as trigger one.
// R4: Either event capture is steered into the fault record store.
// R5: Waveform trigger rising logs initiated and stores waveform; falling logs reset.
// R6: Close input edges log close enabled/disabled only, never a breaker close.
// R7: Normally-open aux record says closed or opened from its level when logged.
// R8: Normally-closed aux record says closed or opened from its level when logged.
// R9: Aux records carry only the input value, not a verified breaker position.
// R10: Negative sequence enable edges log records and enable the element if used.
// R11: Phase directional enable edges log records and gate the element if used.
// R12: Ground directional enable edges log records and gate the element if used.
// R13: Each user input one to eleven logs closed on rise, opened on fall.
// R14: User input eleven records carry input eleven's own index.
// R15: Trip command input rising logs external-trip-enabled, no breaker trip implied.
module oprl_recorder
(
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic extTripCmd,
    input wire logic extCloseCmd,
    input wire logic event_capture_trigger_one,
    input wire logic event_capture_trigger_two,
    input wire logic waveform_capture_trigger,
    input wire logic breaker_aux_normally_open,
    input wire logic breaker_aux_normally_closed,
    input wire logic negSeqOvercurrentEnable,
    input wire logic phase_directional_overcurrent_enable,
    input wire logic ground_directional_overcurrent_enable,
    input wire logic [10:0] user_logic_input,
    input wire logic negSeqUsed,
    input wire logic phaseDirUsed,
    input wire logic groundDirUsed,
    output logic recValid_r,
    output logic [oprl_pkg::CODE_W-1:0] recCode_r,
    output logic recLevel_r,
    output logic evCapStart_r,
    output logic [1:0] evCapSource_r,
    output logic waveCapStart_r,
    output logic negSeqElemEnable_r,
    output logic phaseDirElemEnable_r,
    output logic groundDirElemEnable_r
);

    // ------------------------------------------------------------
    // Input gathering and synchronisation
    // ------------------------------------------------------------
    logic [oprl_pkg::IN_W-1:0] rawIn;
    logic [oprl_pkg::IN_W-1:0] lvl;
    logic [oprl_pkg::IN_W-1:0] rise;
    logic [oprl_pkg::IN_W-1:0] fall;

    // Bit order matches the index constants; user inputs fill the top
    assign rawIn = {user_logic_input,
                    ground_directional_overcurrent_enable,
                    phase_directional_overcurrent_enable,
                    negSeqOvercurrentEnable,
                    breaker_aux_normally_closed,
                    breaker_aux_normally_open,
                    waveform_capture_trigger,
                    event_capture_trigger_two,
                    event_capture_trigger_one,
                    extCloseCmd,
                    extTripCmd};

    oprl_input_sync uSync
    (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .rawIn(rawIn),
        .level(lvl),
        .rise(rise),
        .fall(fall)
    );

    // ------------------------------------------------------------
    // Pending record vector: bit 2i+1 rise of input i, bit 2i its fall
    // ------------------------------------------------------------
    logic [oprl_pkg::PEND_W-1:0] setVec;
    logic [oprl_pkg::PEND_W-1:0] pend_r;
    logic [oprl_pkg::PEND_W-1:0] pend_nxt;
    logic [oprl_pkg::PEND_W-1:0] grantVec;
    logic [oprl_pkg::CODE_W-1:0] grantIdx;
    logic grantHit;

    genvar i;
    generate
        for (i = 0; i < oprl_pkg::IN_W; i++)
        begin : gEdge
            // R13: user input edges queued
            // Every input, user inputs included, queues both edge kinds;
            // index stays the input's own slot, so user input eleven logs as index 20 (code 0x29 on rise).
            // R14: own index kept
            assign setVec[2*i+1] = rise[i];
            assign setVec[2*i] = fall[i];
        end
    endgenerate

    // Lowest index wins; a burst of edges drains one record per cycle
    always_comb
    begin
        grantIdx = oprl_pkg::RST_CODE;
        grantHit = 1'b0;
        for (int k = oprl_pkg::PEND_W - 1; k >= 0; k--)
        begin
            if (pend_r[k])
            begin
                grantIdx = 6'(k);
                grantHit = 1'b1;
            end
        end
    end

    assign grantVec = grantHit ? (42'h000_0000_0001 << grantIdx) : oprl_pkg::RST_PEND;
    // A new edge in the cycle its slot drains is kept: set after clear
    assign pend_nxt = (pend_r & ~grantVec) | setVec;

    // Pending storage; an edge repeated before draining merges into one
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
            pend_r <= oprl_pkg::RST_PEND;
        else
            pend_r <= pend_nxt;
    end

    // ------------------------------------------------------------
    // Record formation
    // ------------------------------------------------------------
    logic [4:0] grantIn;
    logic grantIsAux;
    logic grantLvl;
    logic [oprl_pkg::CODE_W-1:0] code_nxt;

    assign grantIn = grantIdx[5:1];
    assign grantLvl = lvl[grantIn];
    // R7: aux open level
    // R8: aux closed level
    assign grantIsAux = (grantIn == oprl_pkg::IDX_AUX_NO) || (grantIn == oprl_pkg::IDX_AUX_NC);
    // R9: input value only
    // Aux records report the level seen now; nothing checks the breaker itself
    assign code_nxt = grantIsAux ? {grantIn, grantLvl} : grantIdx;

    // Log record output, one cycle per record.
    // Trip and close records are plain input state; no breaker command results.
    // R1: trip disabled record
    // R15: trip enabled record
    // R6: close state only
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            recValid_r <= 1'b0;
            recCode_r <= oprl_pkg::RST_CODE;
            recLevel_r <= 1'b0;
        end
        else
        begin
            recValid_r <= grantHit;
            recCode_r <= code_nxt;
            recLevel_r <= grantLvl;
        end
    end

    // ------------------------------------------------------------
    // Capture strobes and element enables
    // ------------------------------------------------------------
    logic [1:0] evSrc_nxt;

    // R2: trigger one capture
    // R3: trigger two capture
    assign evSrc_nxt = {rise[oprl_pkg::IDX_EVCAP_TWO], rise[oprl_pkg::IDX_EVCAP_ONE]};

    // Captures start at once, not when the log record drains.
    // R4: fault store capture
    // R5: waveform capture start
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            evCapStart_r <= 1'b0;
            evCapSource_r <= 2'b00;
            waveCapStart_r <= 1'b0;
        end
        else
        begin
            evCapStart_r <= |evSrc_nxt;
            evCapSource_r <= evSrc_nxt;
            waveCapStart_r <= rise[oprl_pkg::IDX_WAVECAP];
        end
    end

    // Enables follow the synced level, gated by whether the element is used
    // R10: negative sequence gate
    // R11: phase directional gate
    // R12: ground directional gate
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            negSeqElemEnable_r <= 1'b0;
            phaseDirElemEnable_r <= 1'b0;
            groundDirElemEnable_r <= 1'b0;
        end
        else
        begin
            negSeqElemEnable_r <= negSeqUsed & lvl[oprl_pkg::IDX_NEGSEQ];
            phaseDirElemEnable_r <= phaseDirUsed & lvl[oprl_pkg::IDX_PHASEDIR];
            groundDirElemEnable_r <= groundDirUsed & lvl[oprl_pkg::IDX_GROUNDDIR];
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_trip_rise_queued: assert property ( // R15
        @(posedge clk_sys) disable iff (sys_rst)
        rise[oprl_pkg::IDX_EXT_TRIP] |=> pend_r[1] || (recValid_r && recCode_r == 6'h01))
        else $error("trip rise not queued");

    a_trip_fall_queued: assert property ( // R1
        @(posedge clk_sys) disable iff (sys_rst)
        fall[oprl_pkg::IDX_EXT_TRIP] |=> pend_r[0])
        else $error("trip fall not queued");

    a_evcap_one_start: assert property ( // R2
        @(posedge clk_sys) disable iff (sys_rst)
        rise[oprl_pkg::IDX_EVCAP_ONE] |=> evCapStart_r && evCapSource_r[0])
        else $error("event capture one missing");

    a_evcap_two_start: assert property ( // R3
        @(posedge clk_sys) disable iff (sys_rst)
        rise[oprl_pkg::IDX_EVCAP_TWO] |=> evCapStart_r && evCapSource_r[1])
        else $error("event capture two missing");

    a_evcap_no_spurious: assert property ( // R4
        @(posedge clk_sys) disable iff (sys_rst)
        evCapStart_r |-> $past(rise[oprl_pkg::IDX_EVCAP_ONE] | rise[oprl_pkg::IDX_EVCAP_TWO]))
        else $error("event capture without trigger");

    a_wave_start: assert property ( // R5
        @(posedge clk_sys) disable iff (sys_rst)
        rise[oprl_pkg::IDX_WAVECAP] |=> waveCapStart_r ##1 !waveCapStart_r)
        else $error("waveform capture strobe wrong");

    a_aux_no_level: assert property ( // R7
        @(posedge clk_sys) disable iff (sys_rst)
        recValid_r && recCode_r[5:1] == oprl_pkg::IDX_AUX_NO |-> recCode_r[0] == $past(lvl[5]))
        else $error("aux open record level wrong");

    a_aux_nc_level: assert property ( // R8
        @(posedge clk_sys) disable iff (sys_rst)
        recValid_r && recCode_r[5:1] == oprl_pkg::IDX_AUX_NC |-> recCode_r[0] == $past(lvl[6]))
        else $error("aux closed record level wrong");

    a_negseq_enable: assert property ( // R10
        @(posedge clk_sys) disable iff (sys_rst)
        ##1 negSeqElemEnable_r == $past(negSeqUsed & lvl[oprl_pkg::IDX_NEGSEQ]))
        else $error("negative sequence enable wrong");

    a_phasedir_enable: assert property ( // R11
        @(posedge clk_sys) disable iff (sys_rst)
        phaseDirUsed && rise[oprl_pkg::IDX_PHASEDIR] |=> phaseDirElemEnable_r)
        else $error("phase directional enable wrong");

    a_grounddir_disable: assert property ( // R12
        @(posedge clk_sys) disable iff (sys_rst)
        fall[oprl_pkg::IDX_GROUNDDIR] |=> !groundDirElemEnable_r)
        else $error("ground directional disable wrong");

    a_close_rise_queued: assert property ( // R6
        @(posedge clk_sys) disable iff (sys_rst)
        rise[oprl_pkg::IDX_EXT_CLOSE] |=> pend_r[3])
        else $error("close rise not queued");

    a_close_fall_queued: assert property ( // R6
        @(posedge clk_sys) disable iff (sys_rst)
        fall[oprl_pkg::IDX_EXT_CLOSE] |=> pend_r[2])
        else $error("close fall not queued");

    a_aux_code_level: assert property ( // R9
        @(posedge clk_sys) disable iff (sys_rst)
        recValid_r && (recCode_r[5:1] == oprl_pkg::IDX_AUX_NO || recCode_r[5:1] == oprl_pkg::IDX_AUX_NC)
        |-> recCode_r[0] == recLevel_r)
        else $error("aux record level and code disagree");

    a_user_one_queued: assert property ( // R13
        @(posedge clk_sys) disable iff (sys_rst)
        rise[oprl_pkg::IDX_USER_BASE] |=> pend_r[21])
        else $error("user input one rise not queued");

    a_pend_drains: assert property ( // R13
        @(posedge clk_sys) disable iff (sys_rst)
        (pend_r != oprl_pkg::RST_PEND) |=> recValid_r)
        else $error("pending record not emitted");

    a_user_eleven_code: assert property ( // R14
        @(posedge clk_sys) disable iff (sys_rst)
        pend_r == oprl_pkg::RST_PEND && $onehot(setVec) && rise[oprl_pkg::IDX_USER_LAST]
        |=> ##1 recValid_r && recCode_r == 6'h29)
        else $error("user input eleven record code wrong");

endmodule // oprl_recorder

// ==== core/oprl_pkg.sv ====
/*
 * Shared constants for the operations log input event recorder: input bit
 * positions, record code layout and reset values.
 * Assumes a single system clock; nothing here is tied to a bus or register map.
 */
package oprl_pkg;

    // ------------------------------------------------------------
    // Input vector layout
    // ------------------------------------------------------------
    localparam int unsigned IN_W = 21;
    localparam logic [4:0] IDX_EXT_TRIP = 5'h00;
    localparam logic [4:0] IDX_EXT_CLOSE = 5'h01;
    localparam logic [4:0] IDX_EVCAP_ONE = 5'h02;
    localparam logic [4:0] IDX_EVCAP_TWO = 5'h03;
    localparam logic [4:0] IDX_WAVECAP = 5'h04;
    localparam logic [4:0] IDX_AUX_NO = 5'h05;
    localparam logic [4:0] IDX_AUX_NC = 5'h06;
    localparam logic [4:0] IDX_NEGSEQ = 5'h07;
    localparam logic [4:0] IDX_PHASEDIR = 5'h08;
    localparam logic [4:0] IDX_GROUNDDIR = 5'h09;
    // User logical input n (1..11) sits at IDX_USER_BASE + n - 1
    localparam logic [4:0] IDX_USER_BASE = 5'h0A;
    localparam logic [4:0] IDX_USER_LAST = 5'h14;

    // ------------------------------------------------------------
    // Record code: {input index, direction}, direction 1 = asserted/closed
    // ------------------------------------------------------------
    localparam int unsigned CODE_W = 6;
    localparam int unsigned PEND_W = 2 * IN_W;
    localparam logic DIR_SET = 1'b1;
    localparam logic DIR_CLR = 1'b0;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [CODE_W-1:0] RST_CODE = 6'h00;
    localparam logic [PEND_W-1:0] RST_PEND = 42'h000_0000_0000;
    localparam logic [IN_W-1:0] RST_LEVEL = 21'h00_0000;

endpackage

// ==== core/oprl_input_sync.sv ====
/*
 * Two-flop synchroniser plus edge detector for the whole logical input vector.
 * Assumes the inputs arrive from logic outside clk_sys; the first flop of each
 * chain feeds only the second.
 */
`timescale 1ns/1ps

module oprl_input_sync
(
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic [oprl_pkg::IN_W-1:0] rawIn,
    output logic [oprl_pkg::IN_W-1:0] level,
    output logic [oprl_pkg::IN_W-1:0] rise,
    output logic [oprl_pkg::IN_W-1:0] fall
);

    // ------------------------------------------------------------
    // Per-bit synchroniser and history
    // ------------------------------------------------------------
    genvar b;
    generate
        for (b = 0; b < oprl_pkg::IN_W; b++)
        begin : gBit
            logic meta_r;
            logic sync_r;
            logic prev_r;
            // Meta stage, stable stage, then one cycle of history for edges
            always_ff @(posedge clk_sys or posedge sys_rst)
            begin
                if (sys_rst)
                begin
                    meta_r <= 1'b0;
                    sync_r <= 1'b0;
                    prev_r <= 1'b0;
                end
                else
                begin
                    meta_r <= rawIn[b];
                    sync_r <= meta_r;
                    prev_r <= sync_r;
                end
            end
            // Edges come from the stable stages only
            assign level[b] = sync_r;
            assign rise[b] = sync_r & ~prev_r;
            assign fall[b] = ~sync_r & prev_r;
        end
    endgenerate

endmodule // oprl_input_sync

// ==== tb/oprl_logic_model.sv ====
/*
 * Behavioural model of the relay's programmable logic mapping, which sets the
 * logical input levels that the recorder watches.
 * Assumes the bench hands it a whole new input vector with a one-cycle write.
 */
`timescale 1ns/1ps

module oprl_logic_model
(
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic cmdWe,
    input wire logic [oprl_pkg::IN_W-1:0] cmdVec,
    output logic [oprl_pkg::IN_W-1:0] driveVec
);

    // ------------------------------------------------------------
    // Input levels
    // ------------------------------------------------------------
    // Levels change only on a clock edge, so the recorder's synchroniser sees clean steps
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
            driveVec <= oprl_pkg::RST_LEVEL;
        else if (cmdWe)
            driveVec <= cmdVec;
    end

endmodule // oprl_logic_model

// ==== tb/testbench.sv ====
/*
 * Self-checking bench for the operations log input event recorder.
 * Assumes a single 25 MHz clock; the logic model drives all logical inputs.
 */
`timescale 1ns/1ps

module testbench;

    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic clk_sys;
    logic sys_rst;
    logic cmdWe;
    logic [20:0] cmdVec;
    logic [20:0] drv;
    logic [2:0] used;
    logic recValid_r;
    logic [5:0] recCode_r;
    logic recLevel_r;
    logic evCapStart_r;
    logic [1:0] evCapSource_r;
    logic waveCapStart_r;
    logic [2:0] elemEn;
    int n_mismatch;
    int n_tests;

    oprl_logic_model oprl_logic_model_i (.clk_sys(clk_sys), .sys_rst(sys_rst), .cmdWe(cmdWe),
        .cmdVec(cmdVec), .driveVec(drv));

    oprl_recorder oprl_recorder_i (.clk_sys(clk_sys), .sys_rst(sys_rst), .extTripCmd(drv[0]),
        .extCloseCmd(drv[1]), .event_capture_trigger_one(drv[2]), .event_capture_trigger_two(drv[3]),
        .waveform_capture_trigger(drv[4]), .breaker_aux_normally_open(drv[5]),
        .breaker_aux_normally_closed(drv[6]), .negSeqOvercurrentEnable(drv[7]),
        .phase_directional_overcurrent_enable(drv[8]), .ground_directional_overcurrent_enable(drv[9]),
        .user_logic_input(drv[20:10]), .negSeqUsed(used[0]), .phaseDirUsed(used[1]),
        .groundDirUsed(used[2]), .recValid_r(recValid_r), .recCode_r(recCode_r), .recLevel_r(recLevel_r),
        .evCapStart_r(evCapStart_r), .evCapSource_r(evCapSource_r), .waveCapStart_r(waveCapStart_r),
        .negSeqElemEnable_r(elemEn[0]), .phaseDirElemEnable_r(elemEn[1]),
        .groundDirElemEnable_r(elemEn[2]));

    // ------------------------------------------------------------
    // Clock, reset and watchdog
    // ------------------------------------------------------------
    initial
    begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    // Whole run is under 500 cycles; the limit leaves ample slack
    initial
    begin
        repeat (5000) @(posedge clk_sys);
        n_mismatch++;
        give_verdict();
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
        n_tests++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // New levels land on the model at the second edge
    task automatic drive(input logic [20:0] vec);
        @(posedge clk_sys);
        cmdWe <= 1'b1;
        cmdVec <= vec;
        @(posedge clk_sys);
        cmdWe <= 1'b0;
    endtask

    // Waits at most maxWait edges; stays in the cycle of the record
    task automatic expect_rec(input logic [5:0] code, input logic lvl, input int maxWait);
        int k;
        k = 0;
        do
        begin
            @(posedge clk_sys);
            #1;
            k++;
        end while (recValid_r !== 1'b1 && k < maxWait);
        check({recValid_r, recLevel_r, recCode_r}, {1'b1, lvl, code}, "record");
    endtask

    task automatic wait_strobe(input bit wave);
        int k;
        k = 0;
        do
        begin
            @(posedge clk_sys);
            #1;
            k++;
        end while ((wave ? waveCapStart_r : evCapStart_r) !== 1'b1 && k < 10);
    endtask

    task automatic give_verdict();
        $display("mismatches %0d comparisons %0d", n_mismatch, n_tests);
        if (n_mismatch == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    // Every input raised and lowered alone; aux records follow the level
    task automatic walk_all();
        logic [20:0] vec;
        for (int i = 0; i < 21; i++)
        begin
            vec = 21'h00_0000;
            vec[i] = 1'b1;
            drive(vec);
            expect_rec(6'(2 * i + 1), 1'b1, 60);
            drive(21'h00_0000);
            expect_rec(6'(2 * i), 1'b0, 60);
        end
    endtask

    // Each trigger alone, then both event triggers in the same cycle
    task automatic capture_check();
        logic [20:0] vec;
        for (int j = 0; j < 3; j++)
        begin
            vec = 21'h00_0000;
            vec[2 + j] = 1'b1;
            drive(vec);
            wait_strobe(j == 2);
            if (j < 2)
                check({6'h00, evCapSource_r}, 8'(1 << j), "event source");
            check({6'h00, evCapStart_r, waveCapStart_r}, (j < 2) ? 8'h02 : 8'h01, "strobes");
            expect_rec(6'(2 * j + 5), 1'b1, 1);
            check({6'h00, evCapStart_r, waveCapStart_r}, 8'h00, "strobe width");
            drive(21'h00_0000);
            expect_rec(6'(2 * j + 4), 1'b0, 60);
        end
        drive(21'h00_000C);
        wait_strobe(1'b0);
        check({6'h00, evCapSource_r}, 8'h03, "both sources");
        expect_rec(6'h05, 1'b1, 1);
        expect_rec(6'h07, 1'b1, 1);
        drive(21'h00_0000);
        expect_rec(6'h04, 1'b0, 60);
        expect_rec(6'h06, 1'b0, 1);
    endtask

    // Element gates follow input and used setting
    task automatic element_check();
        logic [20:0] vec;
        for (int j = 0; j < 3; j++)
        begin
            @(posedge clk_sys);
            used <= 3'b111;
            vec = 21'h00_0000;
            vec[7 + j] = 1'b1;
            drive(vec);
            expect_rec(6'(2 * j + 15), 1'b1, 60);
            check({5'h00, elemEn}, 8'(1 << j), "enabled");
            @(posedge clk_sys);
            used <= 3'b000;
            repeat (3) @(posedge clk_sys);
            #1;
            check({5'h00, elemEn}, 8'h00, "unused element");
            drive(21'h00_0000);
            expect_rec(6'(2 * j + 14), 1'b0, 60);
        end
    endtask

    // Simultaneous edges come out lowest code first, back to back
    task automatic order_check();
        drive(21'h10_0001);
        expect_rec(6'h01, 1'b1, 60);
        expect_rec(6'h29, 1'b1, 1);
        drive(21'h00_0000);
        expect_rec(6'h00, 1'b0, 60);
        expect_rec(6'h28, 1'b0, 1);
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        n_mismatch = 0;
        n_tests = 0;
        sys_rst = 1'b1;
        cmdWe = 1'b0;
        cmdVec = 21'h00_0000;
        used = 3'b000;
        repeat (8) @(posedge clk_sys);
        sys_rst <= 1'b0;
        @(posedge clk_sys);
        #1;
        check({recValid_r, evCapStart_r, waveCapStart_r, elemEn, 2'b00}, 8'h00, "after reset");
        walk_all();
        capture_check();
        element_check();
        order_check();
        give_verdict();
    end

endmodule // testbench
